// [hw/jms_params.svh]
// Offsets, field positions, reset values and clock rates of the scan master
`ifndef JMS_PARAMS_SVH
`define JMS_PARAMS_SVH

// Register byte offsets
`define JMS_OFS_CONFIG 8'h70
`define JMS_OFS_STATUS 8'h74
`define JMS_OFS_CAPTURE 8'h78
`define JMS_OFS_DATA_OUT 8'h7C
`define JMS_OFS_MODE_SEL 8'h80
`define JMS_OFS_COMMAND 8'h84
`define JMS_OFS_IRQ_STATUS 8'h88
`define JMS_OFS_IRQ_MASK 8'h8C

// Config fields
`define JMS_CFG_DIR_BIT 3
`define JMS_CFG_RATE_MSB 2
`define JMS_CFG_RATE_LSB 0
`define JMS_CFG_RESET 4'h3

// Status and command fields
`define JMS_STAT_ACTIVE_BIT 0
`define JMS_CMD_LEN_MSB 4
`define JMS_IRQ_DONE_BIT 0
`define JMS_WORD_RESET 32'h0000_0000

// Master clock rate and system clock rate in MHz
`define JMS_MASTER_MHZ 9'd48
`define JMS_SYSCLK_MHZ 9'd250

`endif

// [hw/jms_pkg.sv]
// Types of the scan master shift engine
package jms_pkg;

  typedef enum logic [2:0] {
    JMS_IDLE = 3'b001,
    JMS_LOW = 3'b010,
    JMS_HIGH = 3'b100
  } jms_state_t;

endpackage

// [hw/jms_engine.sv]
// Register-driven scan master shift engine with its register port and interrupt
// Summary of operation
// - Config bit 3 is a read/write port-direction bit that resets to 0.
// - Direction 1 makes the port a master driving the scan pins, 0 a slave.
// - The shift clock comes from a 48 MHz base, code 1 is 24 MHz, each code halves it.
// - The activity flag in status bit 0 is set when the command register is written.
// - The activity flag returns to 0 once every requested bit has been shifted.
// - One to 32 bits from the target output pin fill the capture word from bit 0.
// - One to 32 bits of the data-out word go to the data pin, bit 0 first.
// - One to 32 bits of the mode-select word go to the mode pin, bit 0 first.
// - All shifting runs at the rate selected by the config rate field.
// - Capture, data-out and mode-select words are read/write and reset to zero.
// - In master mode a command write starts clocking and shifting.
// - A command shifts and pulses the scan clock count plus one times.
// - Output pins change on the scan clock fall and input is sampled on the rise.
// - In slave mode command writes are ignored and the flag does not change.
`timescale 1ns/1ps
`include "jms_params.svh"

module jms_engine (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic irq_out,
  output logic scan_clk_out,
  output logic scan_clk_oe_out,
  output logic mode_sel_out,
  output logic mode_sel_oe_out,
  output logic data_out_out,
  output logic data_out_oe_out,
  input wire logic data_in_in
);

  // Half period of the shift clock in 48 MHz ticks
  function automatic logic [6:0] jms_half_ticks(input logic [2:0] code);
    logic [6:0] ticks;
    ticks = 7'h01;
    // Reserved code 0 is run as code 1 so the engine never stalls
    if (code > 3'h1) begin
      ticks = 7'(7'h01 << (code - 3'h1));
    end
    return ticks;
  endfunction

  // Register strobe decode
  function automatic logic jms_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Register state
  logic [3:0] cfg_q;
  logic [3:0] cfg_d;
  logic [31:0] capture_q;
  logic [31:0] capture_d;
  logic [31:0] data_word_q;
  logic [31:0] data_word_d;
  logic [31:0] mode_word_q;
  logic [31:0] mode_word_d;
  logic irq_stat_q;
  logic irq_stat_d;
  logic irq_mask_q;
  logic irq_mask_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Engine state
  jms_pkg::jms_state_t state_q;
  jms_pkg::jms_state_t state_d;
  logic active_q;
  logic active_d;
  logic [4:0] len_q;
  logic [4:0] len_d;
  logic [4:0] idx_q;
  logic [4:0] idx_d;
  logic [6:0] div_q;
  logic [6:0] div_d;
  logic sclk_q;
  logic sclk_d;
  logic mode_pin_q;
  logic mode_pin_d;
  logic data_pin_q;
  logic data_pin_d;

  // Base tick state
  logic [8:0] acc_q;
  logic [8:0] acc_d;
  logic tick;

  // Input synchroniser
  logic din_meta_q;
  logic din_sync_q;

  logic master;
  logic cmd_wr;
  logic start;
  logic done_evt;
  logic edge_due;

  // Rate and capture helpers
  logic [6:0] half_ticks;
  logic sample_now;
  logic [31:0] cap_take;

  assign master = cfg_q[`JMS_CFG_DIR_BIT];
  assign cmd_wr = wr_in && jms_hit(addr_in, `JMS_OFS_COMMAND);
  // A command while busy is dropped so a running shift is never cut
  // master-only start
  assign start = cmd_wr && master && !active_q;

  // 48 MHz base ticks
  // Exact only on average: ticks fall 5 or 6 clocks apart
  always_comb begin
    acc_d = 9'(acc_q + `JMS_MASTER_MHZ);
    tick = 1'b0;
    if (acc_d >= `JMS_SYSCLK_MHZ) begin
      acc_d = 9'(acc_d - `JMS_SYSCLK_MHZ);
      tick = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_q <= 9'h000;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Two flops before the target output is used
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      din_meta_q <= 1'b0;
      din_sync_q <= 1'b0;
    end else begin
      din_meta_q <= data_in_in;
      din_sync_q <= din_meta_q;
    end
  end

  assign edge_due = tick && (div_q == 7'h01);
  // one rate decode
  // Rate changes mid-command take effect at the next edge
  assign half_ticks = jms_half_ticks(cfg_q[`JMS_CFG_RATE_MSB:`JMS_CFG_RATE_LSB]);

  assign sample_now = (state_q == jms_pkg::JMS_LOW) && edge_due;

  // One enable per capture bit keeps the write path free of a wide index decode
  generate
    for (genvar b = 0; b < 32; b++) begin : g_cap
      assign cap_take[b] = sample_now && (idx_q == 5'(b));
    end
  endgenerate

  // Shift sequencer
  always_comb begin
    state_d = state_q;
    active_d = active_q;
    len_d = len_q;
    idx_d = idx_q;
    div_d = div_q;
    sclk_d = sclk_q;
    mode_pin_d = mode_pin_q;
    data_pin_d = data_pin_q;
    done_evt = 1'b0;
    if (tick && div_q != 7'h01) begin
      div_d = 7'(div_q - 7'h01);
    end
    unique case (state_q)
      jms_pkg::JMS_IDLE: begin
        if (start) begin
          active_d = 1'b1;
          len_d = wdata_in[`JMS_CMD_LEN_MSB:0];
          idx_d = 5'h00;
          div_d = half_ticks;
          mode_pin_d = mode_word_q[0];
          data_pin_d = data_word_q[0];
          state_d = jms_pkg::JMS_LOW;
        end
      end
      jms_pkg::JMS_LOW: begin
        if (edge_due) begin
          sclk_d = 1'b1;
          div_d = half_ticks;
          state_d = jms_pkg::JMS_HIGH;
        end
      end
      jms_pkg::JMS_HIGH: begin
        if (edge_due) begin
          sclk_d = 1'b0;
          div_d = half_ticks;
          if (idx_q == len_q) begin
            active_d = 1'b0;
            done_evt = 1'b1;
            state_d = jms_pkg::JMS_IDLE;
          end else begin
            idx_d = 5'(idx_q + 5'h01);
            mode_pin_d = mode_word_q[idx_d];
            data_pin_d = data_word_q[idx_d];
            state_d = jms_pkg::JMS_LOW;
          end
        end
      end
      // Illegal state code: park idle with the clock low
      default: begin
        state_d = jms_pkg::JMS_IDLE;
        active_d = 1'b0;
        sclk_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= jms_pkg::JMS_IDLE;
      active_q <= 1'b0;
      len_q <= 5'h00;
      idx_q <= 5'h00;
      div_q <= 7'h01;
      sclk_q <= 1'b0;
      mode_pin_q <= 1'b0;
      data_pin_q <= 1'b0;
    end else begin
      state_q <= state_d;
      active_q <= active_d;
      len_q <= len_d;
      idx_q <= idx_d;
      div_q <= div_d;
      sclk_q <= sclk_d;
      mode_pin_q <= mode_pin_d;
      data_pin_q <= data_pin_d;
    end
  end

  // Register writes and engine updates
  always_comb begin
    cfg_d = cfg_q;
    capture_d = capture_q;
    data_word_d = data_word_q;
    mode_word_d = mode_word_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    if (wr_in) begin
      if (jms_hit(addr_in, `JMS_OFS_CONFIG)) begin
        cfg_d = wdata_in[3:0];
      end
      if (jms_hit(addr_in, `JMS_OFS_CAPTURE)) begin
        capture_d = wdata_in;
      end
      if (jms_hit(addr_in, `JMS_OFS_DATA_OUT)) begin
        data_word_d = wdata_in;
      end
      if (jms_hit(addr_in, `JMS_OFS_MODE_SEL)) begin
        mode_word_d = wdata_in;
      end
      if (jms_hit(addr_in, `JMS_OFS_IRQ_MASK)) begin
        irq_mask_d = wdata_in[`JMS_IRQ_DONE_BIT];
      end
      if (jms_hit(addr_in, `JMS_OFS_IRQ_STATUS) && wdata_in[`JMS_IRQ_DONE_BIT]) begin
        irq_stat_d = 1'b0;
      end
    end
    // Completion wins over a same-cycle clear
    if (done_evt) begin
      irq_stat_d = 1'b1;
    end
    // sampled bit wins over a write
    capture_d = (capture_d & ~cap_take) | ({32{din_sync_q}} & cap_take);
  end

  // Read mux, data valid the cycle after the strobe
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_in) begin
      unique case (addr_in)
        `JMS_OFS_CONFIG: rdata_d = {28'h000_0000, cfg_q};
        `JMS_OFS_STATUS: rdata_d = {31'h0000_0000, active_q};
        `JMS_OFS_CAPTURE: rdata_d = capture_q;
        `JMS_OFS_DATA_OUT: rdata_d = data_word_q;
        `JMS_OFS_MODE_SEL: rdata_d = mode_word_q;
        `JMS_OFS_IRQ_STATUS: rdata_d = {31'h0000_0000, irq_stat_q};
        `JMS_OFS_IRQ_MASK: rdata_d = {31'h0000_0000, irq_mask_q};
        // Command offset is write-only and reads as zero
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_q <= `JMS_CFG_RESET;
      capture_q <= `JMS_WORD_RESET;
      data_word_q <= `JMS_WORD_RESET;
      mode_word_q <= `JMS_WORD_RESET;
      irq_stat_q <= 1'b0;
      irq_mask_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      cfg_q <= cfg_d;
      capture_q <= capture_d;
      data_word_q <= data_word_d;
      mode_word_q <= mode_word_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_out = rdata_q;
  // Level interrupt, held until a one is written to the status bit or the mask bit is cleared
  assign irq_out = irq_stat_q && irq_mask_q;

  // drive pins only as master
  // Slave mode releases all three pins
  assign scan_clk_out = sclk_q;
  assign mode_sel_out = mode_pin_q;
  assign data_out_out = data_pin_q;
  assign scan_clk_oe_out = master;
  assign mode_sel_oe_out = master;
  assign data_out_oe_out = master;

endmodule // jms_engine

// [dv/jms_properties.sv]
// Port-level checker of the scan master engine
`timescale 1ns/1ps
module jms_properties (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic irq_out,
  input wire logic scan_clk_out,
  input wire logic scan_clk_oe_out,
  input wire logic mode_sel_out,
  input wire logic data_out_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  property p_rd_idle;
    !$past(rd_in) |-> rdata_out == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_dir;
    wr_in && addr_in == 8'h70 |=> scan_clk_oe_out == $past(wdata_in[3]);
  endproperty
  a_dir: assert property (p_dir) else $error("bad pin enable");
  property p_hi_min;
    $rose(scan_clk_out) |-> scan_clk_out[*5];
  endproperty
  a_hi_min: assert property (p_hi_min) else $error("high phase short");
  property p_lo_min;
    $fell(scan_clk_out) |-> !scan_clk_out[*5];
  endproperty
  a_lo_min: assert property (p_lo_min) else $error("low phase short");
  // Pins may also move on the edge that takes the command
  property p_ms_fall;
    $changed(mode_sel_out) |-> $fell(scan_clk_out) || ($past(wr_in) && $past(addr_in) == 8'h84);
  endproperty
  a_ms_fall: assert property (p_ms_fall) else $error("mode pin off fall");
  property p_do_fall;
    $changed(data_out_out) |-> $fell(scan_clk_out) || ($past(wr_in) && $past(addr_in) == 8'h84);
  endproperty
  a_do_fall: assert property (p_do_fall) else $error("data pin off fall");
  property p_rise_mst;
    $rose(scan_clk_out) |-> scan_clk_oe_out;
  endproperty
  a_rise_mst: assert property (p_rise_mst) else $error("clock in slave");
  property p_irq_mask;
    wr_in && addr_in == 8'h8C && !wdata_in[0] |=> !irq_out;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
  c_fall: cover property ($fell(scan_clk_out));
  c_irq: cover property ($rose(irq_out));
  c_cap: cover property (rd_in && addr_in == 8'h78);
endmodule // jms_properties
bind jms_engine jms_properties jms_properties_inst (.clk_in(clk_in), .nrst_in(nrst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .irq_out(irq_out), .scan_clk_out(scan_clk_out),
  .scan_clk_oe_out(scan_clk_oe_out), .mode_sel_out(mode_sel_out),
  .data_out_out(data_out_out));

// [dv/jms_target.sv]
// Behavioural scan target: records shifted bits, returns a test word
`timescale 1ns/1ps
module jms_target (
  input wire logic scan_clk_in,
  input wire logic mode_sel_in,
  input wire logic data_out_in,
  input wire logic oe_in,
  input wire logic clr_in,
  input wire logic [31:0] tx_in,
  output logic data_in_out,
  output logic [31:0] rx_tms_out,
  output logic [31:0] rx_tdi_out,
  output int cnt_out
);
  int idx;
  always @(posedge scan_clk_in or posedge clr_in) begin
    if (clr_in) begin
      cnt_out <= 0;
    end else begin
      rx_tms_out[cnt_out[4:0]] <= mode_sel_in;
      rx_tdi_out[cnt_out[4:0]] <= data_out_in;
      cnt_out <= cnt_out + 1;
    end
  end
  always @(negedge scan_clk_in or posedge clr_in) begin
    if (clr_in) idx <= 0;
    else idx <= cnt_out;
  end
  // Undriven line shows the inverse so a stale value cannot pass
  assign data_in_out = oe_in ? tx_in[idx[4:0]] : ~tx_in[idx[4:0]];
endmodule // jms_target

// [dv/tb.sv]
// Self-checking bench for the scan master shift engine
`timescale 1ns/1ps
module tb;
  logic clk_in, nrst_in, wr_in, rd_in, irq_out, data_in_in, clr, scan_clk_out;
  logic scan_clk_oe_out, mode_sel_out, mode_sel_oe_out, data_out_out, data_out_oe_out;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, tx, rx_tms, rx_tdi, seed, v;
  int error_cnt, n_tests, cnt;
  jms_engine jms_engine_inst (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
    .scan_clk_out(scan_clk_out), .scan_clk_oe_out(scan_clk_oe_out), .mode_sel_out(mode_sel_out),
    .mode_sel_oe_out(mode_sel_oe_out), .data_out_out(data_out_out),
    .data_out_oe_out(data_out_oe_out), .data_in_in(data_in_in));
  jms_target jms_target_inst (.scan_clk_in(scan_clk_out), .mode_sel_in(mode_sel_out),
    .data_out_in(data_out_out), .oe_in(scan_clk_oe_out), .clr_in(clr), .tx_in(tx),
    .data_in_out(data_in_in), .rx_tms_out(rx_tms), .rx_tdi_out(rx_tdi), .cnt_out(cnt));
  always #2 clk_in = ~clk_in;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    d = rdata_out;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic shot(input logic [2:0] code, input logic [4:0] n);
    logic [31:0] tms, tdi, old, m, d;
    int per;
    tms = rnd();
    tdi = rnd();
    old = rnd();
    tx = rnd();
    m = (n == 5'd31) ? 32'hFFFF_FFFF : ((32'h1 << (n + 5'd1)) - 32'h1);
    wr(8'h70, {28'h0, 1'b1, code});
    wr(8'h80, tms);
    wr(8'h7C, tdi);
    chk({29'h0, scan_clk_oe_out, mode_sel_oe_out, data_out_oe_out}, 32'h7);
    wr(8'h78, old);
    clr = 1'b1;
    #1 clr = 1'b0;
    wr(8'h84, {27'h0, n});
    per = -1;
    // The first rise can come before the status read ends, so watch it alongside
    fork
      begin
        rc(8'h74, 32'h1);
        // A command while busy must not restart or lengthen the shift
        if (code > 3'd2) wr(8'h84, 32'h1F);
      end
      begin
        @(posedge scan_clk_out);
        while (scan_clk_out === 1'b1 && per < 9000) begin
          @(negedge clk_in);
          per++;
        end
      end
    join
    // Half period in system clocks, one clock of jitter either way
    chk(32'(per * 48 + 48 >= (250 << (code - 1)) && per * 48 - 48 <= (250 << (code - 1))), 32'h1);
    for (int k = 0; k < 9000; k++) begin
      rd(8'h74, d);
      if (d[0] === 1'b0) break;
    end
    chk(d, 32'h0);
    chk(32'(cnt), {27'h0, n} + 32'h1);
    chk(rx_tms & m, tms & m);
    chk(rx_tdi & m, tdi & m);
    rc(8'h78, (old & ~m) | (tx & m));
    chk({29'h0, scan_clk_out, mode_sel_out, data_out_out}, {30'h0, tms[n], tdi[n]});
    $display("test shift code %0d length %0d done", code, n + 6'd1);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
  initial begin
    clk_in = 1'b0;
    nrst_in = 1'b0;
    {wr_in, rd_in, clr, addr_in, wdata_in, tx, error_cnt, n_tests} = '0;
    seed = 32'h717e;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    rc(8'h70, 32'h3);
    for (int a = 8'h74; a <= 8'h90; a += 4) rc(8'(a), 32'h0);
    wr(8'h84, 32'h1F);
    rc(8'h74, 32'h0);
    chk({29'h0, scan_clk_oe_out, mode_sel_oe_out, data_out_oe_out}, 32'h0);
    for (int a = 8'h78; a <= 8'h80; a += 4) begin
      v = rnd();
      wr(8'(a), v);
      rc(8'(a), v);
    end
    $display("test registers done");
    wr(8'h8C, 32'h1);
    shot(3'd1, 5'd31);
    chk({31'h0, irq_out}, 32'h1);
    wr(8'h8C, 32'h0);
    @(negedge clk_in);
    chk({31'h0, irq_out}, 32'h0);
    wr(8'h8C, 32'h1);
    wr(8'h88, 32'h1);
    @(negedge clk_in);
    chk({31'h0, irq_out}, 32'h0);
    shot(3'd3, 5'd0);
    for (int c = 1; c < 8; c++) shot(3'(c), c > 4 ? 5'(rnd() % 2) : 5'(rnd()));
    conclude();
  end
endmodule // tb
